/* File: shared_pin_io_cfg.svh */
// Constants of the shared pin port block: addresses, reset values, masks,
// port indices and machine cycle timing.
// Assumes inclusion by bare name from every file that needs it.
`ifndef SHARED_PIN_IO_CFG_SVH
`define SHARED_PIN_IO_CFG_SVH

// -----------------------------------------------------------------
// Special function register addresses
// -----------------------------------------------------------------
`define ADDR_PORT1 8'h90
`define ADDR_PORT3 8'hb0
`define ADDR_EXTRA_PORT 8'hd8

// -----------------------------------------------------------------
// Reset values and masks
// -----------------------------------------------------------------
`define PORT8_RESET 8'hff
`define EXTRA_PORT_RESET 8'h0f
`define EXTRA_PORT_MASK 8'h0f
`define FULL_PORT_MASK 8'hff

// -----------------------------------------------------------------
// Machine cycle timing (one state per clock, 100 MHz clock)
// -----------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define STATES_PER_MCYCLE 4'hc
`define STATE_ONE 4'h1
`define STATE_NINE 4'h9
`define STATE_TEN 4'ha
`define STATE_TWELVE 4'hc

// -----------------------------------------------------------------
// Port indices inside the packed port arrays
// -----------------------------------------------------------------
`define IDX_PORT1 2'h0
`define IDX_PORT3 2'h1
`define IDX_EXTRA 2'h2

`endif

/* File: shared_pin_io_pkg.sv */
// Types of the shared pin port block: read-modify-write operations and
// the packed state of the port logic.
// Assumes the configuration header is compiled alongside.
package shared_pin_io_pkg;

  // Read-modify-write operations that take the register, not the pin; RMW_NONE is a plain pin read
  typedef enum logic [3:0] {
    RMW_NONE, RMW_AND, RMW_OR, RMW_XOR, RMW_JBC, RMW_CPL,
    RMW_INC, RMW_DEC, RMW_DJNZ, RMW_MOVC, RMW_CLR, RMW_SETB
  } rmw_op_e;

  // Index 0 is port 1, index 1 is port 3, index 2 is the extra port
  typedef logic [2:0][7:0] port_vec_t;

  typedef struct packed {
    logic [3:0] mstate;
    port_vec_t port_reg;
    port_vec_t pend;
    logic [2:0] pend_v;
    port_vec_t out_stage;
    port_vec_t smp;
    port_vec_t sync1;
    port_vec_t sync2;
    logic [7:0] rdata;
    logic rvalid;
    logic rflag;
  } io_state_s;

endpackage

/* File: rmw_if.sv */
// Carrier between the port control logic and its read-modify-write unit.
// Assumes both ends sit on the same clock; the unit is purely combinational.
`timescale 1ns/100ps
`default_nettype none
interface rmw_if;
  shared_pin_io_pkg::rmw_op_e op;
  logic [2:0] bit_sel;
  logic [7:0] operand;
  logic carry;
  logic [7:0] cur;
  logic [7:0] result;
  logic flag;
  modport alu (input op, input bit_sel, input operand, input carry, input cur,
               output result, output flag);
  modport ctl (output op, output bit_sel, output operand, output carry, output cur,
               input result, input flag);
endinterface
`default_nettype wire

/* File: port_rmw_alu.sv */
// Combinational read-modify-write unit for the port registers.
// Assumes the caller presents the register value, never the pin level.
`timescale 1ns/100ps
`default_nettype none
module port_rmw_alu (
  rmw_if.alu bus
);

  // -----------------------------------------------------------------
  // Operation decode; flag carries the jump condition where one exists
  // -----------------------------------------------------------------
  always_comb begin
    bus.result = bus.cur;
    bus.flag = 1'h0;
    unique case (bus.op)
      shared_pin_io_pkg::RMW_NONE: begin
        bus.result = bus.cur;
      end
      shared_pin_io_pkg::RMW_AND: begin
        bus.result = bus.cur & bus.operand; // [R13]
      end
      shared_pin_io_pkg::RMW_OR: begin
        bus.result = bus.cur | bus.operand; // [R13]
      end
      shared_pin_io_pkg::RMW_XOR: begin
        bus.result = bus.cur ^ bus.operand; // [R13]
      end
      shared_pin_io_pkg::RMW_JBC: begin
        bus.flag = bus.cur[bus.bit_sel]; // [R13]
        bus.result[bus.bit_sel] = 1'h0;
      end
      shared_pin_io_pkg::RMW_CPL: begin
        bus.result[bus.bit_sel] = ~bus.cur[bus.bit_sel]; // [R13]
      end
      shared_pin_io_pkg::RMW_INC: begin
        bus.result = bus.cur + 8'h01; // [R13]
      end
      shared_pin_io_pkg::RMW_DEC: begin
        bus.result = bus.cur - 8'h01; // [R13]
      end
      shared_pin_io_pkg::RMW_DJNZ: begin
        bus.result = bus.cur - 8'h01; // [R13]
        bus.flag = (bus.cur != 8'h01);
      end
      shared_pin_io_pkg::RMW_MOVC: begin
        bus.result[bus.bit_sel] = bus.carry; // [R13]
      end
      shared_pin_io_pkg::RMW_CLR: begin
        bus.result[bus.bit_sel] = 1'h0; // [R13]
      end
      shared_pin_io_pkg::RMW_SETB: begin
        bus.result[bus.bit_sel] = 1'h1; // [R13]
      end
    endcase
  end

endmodule
`default_nettype wire

/* File: shared_pin_io_ports.sv */
// Port logic for ports 1, 3 and the four-pin extra port, with alternate
// function sharing, register/pin read paths and machine cycle timing.
// Assumes the core drives the register strobes on this clock; pins are
// asynchronous and pass two flip-flops before any use.
// Functional notes
// R1: P1.0, P1.1 feed timer 2 inputs
// R2: P1.3..P1.7 carry pulse channels 0..4
// R3: P3.0 serial receive, or sync data line
// R4: P3.1 transmit data, or sync shift clock
// R5: P3.2, P3.3 feed interrupts and timer gates
// R6: P3.4, P3.5 feed timer 0/1 counts
// R7: P3.6/P3.7 drive external write/read strobes
// R8: Extra port register decoded at D8 hex
// R9: Extra register low four bits drive pins
// R10: Extra pins released high after reset
// R11: Read-modify-write takes operand from register
// R12: Plain reads return sampled pin levels
// R13: Full set of register-sourced operations supported
// R14: Register updates at state twelve only
// R15: Output stage lags register one machine cycle
// R16: Port 1 pins sampled at state nine
// R17: Port 3 pins sampled at state ten
// R18: Outside inputs held over one machine cycle
// R19: Software avoids writing extra port when tied
// R20: Zero pulls pin low, one releases it
// R21: Software writes one before using input
// R22: Low alternate output also pulls pin low
`include "shared_pin_io_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module shared_pin_io_ports (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  input wire shared_pin_io_pkg::rmw_op_e rmw_op,
  input wire logic [2:0] rmw_bit,
  input wire logic [7:0] rmw_operand,
  input wire logic rmw_carry,
  output logic [7:0] sfr_rdata,
  output logic sfr_rvalid,
  output logic rmw_flag,
  input wire logic [7:0] p1_in,
  output logic [7:0] p1_out,
  output logic [7:0] p1_oe,
  input wire logic [7:0] p3_in,
  output logic [7:0] p3_out,
  output logic [7:0] p3_oe,
  input wire logic [3:0] p4_in,
  output logic [3:0] p4_out,
  output logic [3:0] p4_oe,
  input wire logic [4:0] pulse_out_ch,
  input wire logic ser_sync_mode,
  input wire logic ser_data_out,
  input wire logic ser_txd,
  input wire logic ser_shift_clk,
  input wire logic xmem_active,
  input wire logic xmem_wr_n,
  input wire logic xmem_rd_n,
  output logic timer2_count_in,
  output logic timer2_aux_in,
  output logic ser_rx_in,
  output logic ext_irq_in_0,
  output logic ext_irq_in_1,
  output logic timer0_gate_in,
  output logic timer1_gate_in,
  output logic timer0_count_in,
  output logic timer1_count_in
);

  // -----------------------------------------------------------------
  // Reset release
  // -----------------------------------------------------------------
  logic rst_s1_r;
  logic rst_n_sync;

  // Async assert, two-flop release so no flop leaves reset on a runt edge
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rst_s1_r <= 1'h0;
      rst_n_sync <= 1'h0;
    end else begin
      rst_s1_r <= 1'h1;
      rst_n_sync <= rst_s1_r;
    end
  end

  // -----------------------------------------------------------------
  // Decode helpers
  // -----------------------------------------------------------------
  // Returns {hit, index}; unmapped addresses give no hit
  function automatic logic [2:0] port_decode(input logic [7:0] addr);
    logic [2:0] d;
    d = 3'h0;
    if (addr == `ADDR_PORT1) d = {1'h1, `IDX_PORT1};
    if (addr == `ADDR_PORT3) d = {1'h1, `IDX_PORT3};
    if (addr == `ADDR_EXTRA_PORT) d = {1'h1, `IDX_EXTRA}; // [R8]
    return d;
  endfunction

  function automatic logic [7:0] port_mask(input logic [1:0] idx);
    return (idx == `IDX_EXTRA) ? `EXTRA_PORT_MASK : `FULL_PORT_MASK; // [R9]
  endfunction

  // Port 1 samples at state nine, port 3 and the extra port at ten
  function automatic logic [3:0] sample_state(input logic [1:0] idx);
    return (idx == `IDX_PORT1) ? `STATE_NINE : `STATE_TEN;
  endfunction

  // -----------------------------------------------------------------
  // State and datapath
  // -----------------------------------------------------------------
  shared_pin_io_pkg::io_state_s state_r;
  shared_pin_io_pkg::io_state_s state_nxt;
  shared_pin_io_pkg::port_vec_t pins_in;
  shared_pin_io_pkg::port_vec_t level;
  logic [2:0] dec;
  logic hit;
  logic [1:0] idx;
  logic [7:0] alt3;
  rmw_if rmw_bus ();

  port_rmw_alu u_alu (
    .bus(rmw_bus)
  );

  assign dec = port_decode(sfr_addr);
  assign hit = dec[2];
  assign idx = dec[1:0];
  assign pins_in = {{4'h0, p4_in}, p3_in, p1_in};

  // Operand view includes a write still waiting for state twelve
  assign rmw_bus.op = rmw_op;
  assign rmw_bus.bit_sel = rmw_bit;
  assign rmw_bus.operand = rmw_operand;
  assign rmw_bus.carry = rmw_carry;
  assign rmw_bus.cur = state_r.pend_v[idx] ? state_r.pend[idx] : state_r.port_reg[idx]; // [R11]

  // Next state: divider, synchronisers, sampling, bus access, commit
  always_comb begin
    state_nxt = state_r;
    state_nxt.mstate = (state_r.mstate == `STATES_PER_MCYCLE) ?
                       `STATE_ONE : state_r.mstate + 4'h1;
    state_nxt.rvalid = sfr_rd;
    state_nxt.rdata = 8'h00;
    state_nxt.rflag = 1'h0;
    for (int i = 0; i < 3; i++) begin
      state_nxt.sync1[i] = pins_in[i] & port_mask(2'(i));
      state_nxt.sync2[i] = state_r.sync1[i];
      // A level shorter than a machine cycle can fall between samples
      if (state_r.mstate == sample_state(2'(i))) begin
        state_nxt.smp[i] = state_r.sync2[i]; // [R16] [R17]
      end
    end
    if (hit && sfr_wr) begin
      state_nxt.pend[idx] = sfr_wdata & port_mask(idx); // [R9]
      state_nxt.pend_v[idx] = 1'h1;
    end
    if (hit && sfr_rd) begin
      if (rmw_op != shared_pin_io_pkg::RMW_NONE) begin
        state_nxt.rdata = rmw_bus.cur; // [R11]
        state_nxt.rflag = rmw_bus.flag;
        state_nxt.pend[idx] = rmw_bus.result & port_mask(idx); // [R11] [R13]
        state_nxt.pend_v[idx] = 1'h1;
      end else begin
        state_nxt.rdata = state_r.smp[idx]; // [R12]
      end
    end
    // Register and output stage move only at the end of state twelve
    if (state_r.mstate == `STATE_TWELVE) begin
      for (int i = 0; i < 3; i++) begin
        state_nxt.out_stage[i] = state_r.port_reg[i]; // [R15]
        if (state_nxt.pend_v[i]) begin
          state_nxt.port_reg[i] = state_nxt.pend[i]; // [R14]
        end
      end
      state_nxt.pend_v = 3'h0;
    end
  end

  // State register; all ports start released high
  always_ff @(posedge clock or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      state_r <= '0;
      state_r.mstate <= `STATE_ONE;
      state_r.port_reg <= {`EXTRA_PORT_RESET, `PORT8_RESET, `PORT8_RESET}; // [R10]
      state_r.out_stage <= {`EXTRA_PORT_RESET, `PORT8_RESET, `PORT8_RESET}; // [R10]
    end else begin
      state_r <= state_nxt;
    end
  end

  // -----------------------------------------------------------------
  // Pin drivers: open low driver, pull-up does the high level
  // -----------------------------------------------------------------
  // Port 3 alternate outputs; idle functions sit at one
  assign alt3 = {xmem_rd_n | ~xmem_active, // [R7]
                 xmem_wr_n | ~xmem_active, // [R7]
                 4'hf,
                 ser_sync_mode ? ser_shift_clk : ser_txd, // [R4]
                 ~ser_sync_mode | ser_data_out}; // [R3]
  assign level[0] = state_r.out_stage[0] & {pulse_out_ch, 3'h7}; // [R2] [R22]
  assign level[1] = state_r.out_stage[1] & alt3; // [R22]
  assign level[2] = state_r.out_stage[2];
  assign p1_out = 8'h00;
  assign p3_out = 8'h00;
  assign p4_out = 4'h0;
  assign p1_oe = ~level[0]; // [R20]
  assign p3_oe = ~level[1]; // [R20]
  assign p4_oe = ~level[2][3:0]; // [R9] [R20]

  // -----------------------------------------------------------------
  // Alternate inputs and bus answer
  // -----------------------------------------------------------------
  assign timer2_count_in = state_r.sync2[0][0]; // [R1]
  assign timer2_aux_in = state_r.sync2[0][1]; // [R1]
  assign ser_rx_in = state_r.sync2[1][0]; // [R3]
  assign ext_irq_in_0 = state_r.sync2[1][2]; // [R5]
  assign ext_irq_in_1 = state_r.sync2[1][3]; // [R5]
  assign timer0_gate_in = state_r.sync2[1][2]; // [R5]
  assign timer1_gate_in = state_r.sync2[1][3]; // [R5]
  assign timer0_count_in = state_r.sync2[1][4]; // [R6]
  assign timer1_count_in = state_r.sync2[1][5]; // [R6]
  assign sfr_rdata = state_r.rdata;
  assign sfr_rvalid = state_r.rvalid;
  assign rmw_flag = state_r.rflag;

  // -----------------------------------------------------------------
  // Assertions and covers
  // -----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n_sync);

  AST_COMMIT_AT_TWELVE: assert property ( // [R14]
    $changed(state_r.port_reg) |-> $past(state_r.mstate) == `STATE_TWELVE)
    else $error("Port register changed outside state twelve");
  AST_OUT_LAGS_REG: assert property ( // [R15]
    state_r.mstate == `STATE_TWELVE |=> state_r.out_stage == $past(state_r.port_reg))
    else $error("Output stage did not take the old register value");
  AST_P1_SAMPLE_NINE: assert property ( // [R16]
    $changed(state_r.smp[0]) |-> $past(state_r.mstate) == `STATE_NINE)
    else $error("Port 1 sampled outside state nine");
  AST_P3_SAMPLE_TEN: assert property ( // [R17]
    $changed(state_r.smp[1]) |-> $past(state_r.mstate) == `STATE_TEN)
    else $error("Port 3 sampled outside state ten");
  AST_PLAIN_READ_PINS: assert property ( // [R12]
    sfr_rd && rmw_op == shared_pin_io_pkg::RMW_NONE && sfr_addr == `ADDR_PORT1
    |=> sfr_rvalid && sfr_rdata == $past(state_r.smp[0]))
    else $error("Plain read did not return sampled pins");
  AST_RMW_READS_REG: assert property ( // [R11]
    sfr_rd && rmw_op != shared_pin_io_pkg::RMW_NONE && sfr_addr == `ADDR_EXTRA_PORT
    && !state_r.pend_v[2] |=> sfr_rdata == $past(state_r.port_reg[2]))
    else $error("Read-modify-write did not use the register");
  AST_EXTRA_UPPER_ZERO: assert property ( // [R9]
    state_r.port_reg[2][7:4] == 4'h0)
    else $error("Unused extra port bits became set");
  AST_PWM_LOW_PULLS: assert property ( // [R22]
    !pulse_out_ch[0] |-> p1_oe[3])
    else $error("Low pulse channel 0 did not pull its pin low");
  AST_XMEM_WR_STROBE: assert property ( // [R7]
    xmem_active && !xmem_wr_n |-> p3_oe[6])
    else $error("Write strobe did not reach its pin");
  AST_EXTRA_RELEASED: assert property ( // [R10]
    $rose(rst_n_sync) |-> p4_oe == 4'h0)
    else $error("Extra port pins not released after reset");

  COV_RMW_EXTRA: cover property (
    sfr_rd && rmw_op == shared_pin_io_pkg::RMW_INC && sfr_addr == `ADDR_EXTRA_PORT);
  COV_WRITE_COMMIT: cover property (
    sfr_wr && hit ##[1:12] state_r.mstate == `STATE_TWELVE);
  COV_SYNC_SERIAL: cover property (ser_sync_mode && !ser_shift_clk);

endmodule
`default_nettype wire

/* File: pin_world.sv */
// Model of the circuitry outside the shared port pins: pull-ups on every
// pin and a way for the bench to pull any pin low from outside.
// Assumes oe high means the device drives the pin to its out level.
`timescale 1ns/100ps
`default_nettype none
module pin_world (
  input wire logic [7:0] p1_oe,
  input wire logic [7:0] p3_oe,
  input wire logic [3:0] p4_oe,
  input wire logic [7:0] p1_out,
  input wire logic [7:0] p3_out,
  input wire logic [3:0] p4_out,
  input wire logic [7:0] p1_ext_low,
  input wire logic [7:0] p3_ext_low,
  input wire logic [3:0] p4_ext_low,
  output logic [7:0] p1_pin,
  output logic [7:0] p3_pin,
  output logic [3:0] p4_pin
);
  // -----------------------------------------------------------------
  // Wired pin level
  // -----------------------------------------------------------------
  // A released pin goes to the pull-up level unless pulled low from outside, never a stale value.
  // No extra pin is tied to the supply here, so register writes are safe
  assign p1_pin = (p1_oe & p1_out) | (~p1_oe & ~p1_ext_low);
  assign p3_pin = (p3_oe & p3_out) | (~p3_oe & ~p3_ext_low);
  assign p4_pin = (p4_oe & p4_out) | (~p4_oe & ~p4_ext_low);
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the shared pin port block.
// Assumes the design config header and package are compiled first.
`include "shared_pin_io_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] init;
    shared_pin_io_pkg::rmw_op_e op;
    logic [2:0] bsel;
    logic [7:0] opnd;
    logic cy;
    logic fl;
    logic [7:0] res;
  } row_s;
  // Address, start value, op, bit, operand, carry, flag, result
  localparam row_s rows [13] = '{
    '{8'h90, 8'hf0, shared_pin_io_pkg::RMW_AND, 3'h0, 8'h3c, 1'b0, 1'b0, 8'h30},
    '{8'hb0, 8'h12, shared_pin_io_pkg::RMW_OR, 3'h0, 8'h40, 1'b0, 1'b0, 8'h52},
    '{8'hd8, 8'h05, shared_pin_io_pkg::RMW_XOR, 3'h0, 8'h0f, 1'b0, 1'b0, 8'h0a},
    '{8'h90, 8'h04, shared_pin_io_pkg::RMW_JBC, 3'h2, 8'h00, 1'b0, 1'b1, 8'h00},
    '{8'hb0, 8'hff, shared_pin_io_pkg::RMW_CPL, 3'h7, 8'h00, 1'b0, 1'b0, 8'h7f},
    '{8'h90, 8'hff, shared_pin_io_pkg::RMW_INC, 3'h0, 8'h00, 1'b0, 1'b0, 8'h00},
    '{8'hd8, 8'h00, shared_pin_io_pkg::RMW_DEC, 3'h0, 8'h00, 1'b0, 1'b0, 8'h0f},
    '{8'hb0, 8'h01, shared_pin_io_pkg::RMW_DJNZ, 3'h0, 8'h00, 1'b0, 1'b0, 8'h00},
    '{8'h90, 8'h02, shared_pin_io_pkg::RMW_DJNZ, 3'h0, 8'h00, 1'b0, 1'b1, 8'h01},
    '{8'h90, 8'hff, shared_pin_io_pkg::RMW_MOVC, 3'h5, 8'h00, 1'b0, 1'b0, 8'hdf},
    '{8'hb0, 8'h00, shared_pin_io_pkg::RMW_MOVC, 3'h6, 8'h00, 1'b1, 1'b0, 8'h40},
    '{8'hb0, 8'hff, shared_pin_io_pkg::RMW_CLR, 3'h0, 8'h00, 1'b0, 1'b0, 8'hfe},
    '{8'hd8, 8'h00, shared_pin_io_pkg::RMW_SETB, 3'h3, 8'h00, 1'b0, 1'b0, 8'h08}};
  // Which pin each alternate input test pulls low, and the expected inputs
  localparam int alt_bit [7] = '{0, 1, 0, 2, 3, 4, 5};
  localparam logic [8:0] alt_exp [7] = '{9'h0ff, 9'h17f, 9'h1bf, 9'h1cf, 9'h1f3, 9'h1fd,
    9'h1fe};
  // Serial and strobe controls against the port 3 drive they should give
  localparam logic [6:0] ctl_vec [6] = '{7'h2b, 7'h53, 7'h3d, 7'h3e, 7'h38, 7'h1b};
  localparam logic [7:0] ctl_exp [6] = '{8'h02, 8'h03, 8'h40, 8'h80, 8'h00, 8'h00};

  logic clock, nrst, sfr_wr, sfr_rd, rmw_carry, sfr_rvalid, rmw_flag, flag;
  logic [7:0] sfr_addr, sfr_wdata, rmw_operand, sfr_rdata, rdata, p1_ext, p3_ext;
  logic [7:0] p1_in, p1_out, p1_oe, p3_in, p3_out, p3_oe;
  logic [3:0] p4_in, p4_out, p4_oe, p4_ext;
  logic [2:0] rmw_bit;
  logic [4:0] pulse_out_ch;
  logic ser_sync_mode, ser_data_out, ser_txd, ser_shift_clk, xmem_active, xmem_wr_n;
  logic xmem_rd_n, timer2_count_in, timer2_aux_in, ser_rx_in, ext_irq_in_0, ext_irq_in_1;
  logic timer0_gate_in, timer1_gate_in, timer0_count_in, timer1_count_in;
  logic [8:0] alt;
  shared_pin_io_pkg::rmw_op_e rmw_op;
  int err_count = 0;
  int checks_done = 0;

  assign alt = {timer2_count_in, timer2_aux_in, ser_rx_in, ext_irq_in_0, timer0_gate_in,
    ext_irq_in_1, timer1_gate_in, timer0_count_in, timer1_count_in};

  shared_pin_io_ports shared_pin_io_ports_i (.clock(clock), .nrst(nrst), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .rmw_op(rmw_op),
    .rmw_bit(rmw_bit), .rmw_operand(rmw_operand), .rmw_carry(rmw_carry),
    .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid), .rmw_flag(rmw_flag), .p1_in(p1_in),
    .p1_out(p1_out), .p1_oe(p1_oe), .p3_in(p3_in), .p3_out(p3_out), .p3_oe(p3_oe),
    .p4_in(p4_in), .p4_out(p4_out), .p4_oe(p4_oe), .pulse_out_ch(pulse_out_ch),
    .ser_sync_mode(ser_sync_mode), .ser_data_out(ser_data_out), .ser_txd(ser_txd),
    .ser_shift_clk(ser_shift_clk), .xmem_active(xmem_active), .xmem_wr_n(xmem_wr_n),
    .xmem_rd_n(xmem_rd_n), .timer2_count_in(timer2_count_in),
    .timer2_aux_in(timer2_aux_in), .ser_rx_in(ser_rx_in), .ext_irq_in_0(ext_irq_in_0),
    .ext_irq_in_1(ext_irq_in_1), .timer0_gate_in(timer0_gate_in),
    .timer1_gate_in(timer1_gate_in), .timer0_count_in(timer0_count_in),
    .timer1_count_in(timer1_count_in));

  pin_world pin_world_i (.p1_oe(p1_oe), .p3_oe(p3_oe), .p4_oe(p4_oe), .p1_out(p1_out),
    .p3_out(p3_out), .p4_out(p4_out), .p1_ext_low(p1_ext), .p3_ext_low(p3_ext),
    .p4_ext_low(p4_ext), .p1_pin(p1_in), .p3_pin(p3_in), .p4_pin(p4_in));

  // -----------------------------------------------------------------
  // Tasks
  // -----------------------------------------------------------------
  task automatic stop_test;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One register cycle; d is write data or the logic operand
  task automatic bus(input logic [7:0] a, input logic wr, input logic [7:0] d,
                     input shared_pin_io_pkg::rmw_op_e op, input logic [2:0] b,
                     input logic cy);
    @(posedge clock);
    sfr_addr <= a;
    sfr_wr <= wr;
    sfr_rd <= !wr;
    sfr_wdata <= d;
    rmw_operand <= d;
    rmw_op <= op;
    rmw_bit <= b;
    rmw_carry <= cy;
    @(posedge clock);
    sfr_wr <= 1'b0;
    sfr_rd <= 1'b0;
    #1;
    if (!wr) begin
      chk("read valid", 9'h001, {8'h00, sfr_rvalid});
      rdata = sfr_rdata;
      flag = rmw_flag;
    end
  endtask

  // -----------------------------------------------------------------
  // Clock and watchdog
  // -----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // A hang counts as a failure and still reaches the report
  initial begin
    repeat (90000) @(posedge clock);
    err_count++;
    stop_test();
  end

  // -----------------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------------
  initial begin
    int n;
    nrst = 1'b0;
    rmw_op = shared_pin_io_pkg::RMW_NONE;
    {sfr_wr, sfr_rd, rmw_carry, rmw_bit, sfr_addr, sfr_wdata, rmw_operand} = '0;
    {p1_ext, p3_ext, p4_ext} = '0;
    {ser_sync_mode, ser_data_out, ser_txd, ser_shift_clk, xmem_active} = 5'h0f;
    {pulse_out_ch, xmem_wr_n, xmem_rd_n} = 7'h7f;
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    repeat (4) @(posedge clock);
    #1;
    chk("released pins", 9'h000, {1'b0, p1_oe | p3_oe | {4'h0, p4_oe}});
    bus(`ADDR_EXTRA_PORT, 1'b0, 8'hff, shared_pin_io_pkg::RMW_AND, 3'h0, 1'b0);
    chk("extra register reset", 9'h00f, {1'b0, rdata});
    repeat (16) @(posedge clock);
    bus(`ADDR_EXTRA_PORT, 1'b0, 8'h00, shared_pin_io_pkg::RMW_NONE, 3'h0, 1'b0);
    chk("extra pins reset", 9'h00f, {1'b0, rdata});
    // Walk a low level through each pulse channel
    for (int k = 0; k < 5; k++) begin
      pulse_out_ch <= ~(5'h01 << k);
      @(posedge clock);
      #1;
      chk("pulse drive", {1'b0, 8'h08 << k}, {1'b0, p1_oe});
    end
    pulse_out_ch <= 5'h1f;
    for (int k = 0; k < 6; k++) begin
      {ser_sync_mode, ser_data_out, ser_txd, ser_shift_clk, xmem_active, xmem_wr_n,
        xmem_rd_n} <= ctl_vec[k];
      @(posedge clock);
      #1;
      chk("serial strobe drive", {1'b0, ctl_exp[k]}, {1'b0, p3_oe});
    end
    {ser_sync_mode, ser_data_out, ser_txd, ser_shift_clk, xmem_active} <= 5'h0f;
    {xmem_wr_n, xmem_rd_n} <= 2'h3;
    // Registers still hold ones, so every pin works as an input here
    for (int k = 0; k < 7; k++) begin
      p1_ext <= (k < 2) ? (8'h01 << alt_bit[k]) : 8'h00;
      p3_ext <= (k < 2) ? 8'h00 : (8'h01 << alt_bit[k]);
      repeat (16) @(posedge clock); // held beyond one machine cycle
      #1;
      chk("alternate inputs", alt_exp[k], alt);
      bus((k < 2) ? `ADDR_PORT1 : `ADDR_PORT3, 1'b0, 8'h00, shared_pin_io_pkg::RMW_NONE,
        3'h0, 1'b0);
      chk("pin sample", {1'b0, ~(8'h01 << alt_bit[k])}, {1'b0, rdata});
    end
    // Release the outside pulls once, after the last input case
    p1_ext <= 8'h00;
    p3_ext <= 8'h00;
    // Ordinary cases: every register-sourced operation
    foreach (rows[i]) begin
      bus(rows[i].addr, 1'b1, rows[i].init, shared_pin_io_pkg::RMW_NONE, 3'h0, 1'b0);
      bus(rows[i].addr, 1'b0, rows[i].opnd, rows[i].op, rows[i].bsel, rows[i].cy);
      chk("rmw operand", {1'b0, rows[i].init}, {1'b0, rdata});
      chk("rmw flag", {8'h00, rows[i].fl}, {8'h00, flag});
      bus(rows[i].addr, 1'b0, 8'hff, shared_pin_io_pkg::RMW_AND, 3'h0, 1'b0);
      chk("rmw result", {1'b0, rows[i].res}, {1'b0, rdata});
      repeat (44) @(posedge clock);
      bus(rows[i].addr, 1'b0, 8'h00, shared_pin_io_pkg::RMW_NONE, 3'h0, 1'b0);
      chk("pin read", {1'b0, rows[i].res}, {1'b0, rdata});
    end
    // Write to pin lag: commit at state twelve, output one machine cycle later
    bus(`ADDR_PORT1, 1'b1, 8'hff, shared_pin_io_pkg::RMW_NONE, 3'h0, 1'b0);
    repeat (30) @(posedge clock);
    bus(`ADDR_PORT1, 1'b1, 8'h00, shared_pin_io_pkg::RMW_NONE, 3'h0, 1'b0);
    n = 0;
    while (p1_oe !== 8'hff && n < 30) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk("output lag in range", 9'h001, {8'h00, (n >= 12 && n <= 23)});
    // Unmapped address: write dropped, read answers zero
    bus(8'h91, 1'b1, 8'h5a, shared_pin_io_pkg::RMW_NONE, 3'h0, 1'b0);
    bus(8'h91, 1'b0, 8'h00, shared_pin_io_pkg::RMW_NONE, 3'h0, 1'b0);
    chk("unmapped read", 9'h000, {1'b0, rdata});
    stop_test();
  end
endmodule
`default_nettype wire
